/* File: rtl/bb_cfg_pkg.sv */
// Constants shared by both ends of the baseband configuration control bus.
// Assumes one 200 MHz clock and a synchronous active-high reset on both ends.
// Notes on behaviour
// - Identity at zero: part and version nibbles
// - Bits 7/6 invert receive/transmit quadrature sample
// - Bit 5 inverts transmit output clock
// - Bit 4 makes transmit-ready active low
// - Bit 3 treats transmit enable active low
// - Bit 2 makes channel-assessment output active high
// - Bit 1 makes receive-data-ready active low
// - Bit 0 inverts receive clock output
// - Host sets init control with enables inactive
// - Init bit clears learned state, resets gain
// - Host: set init, load acquisition, clear
// - Short mode loads short preamble length
// - Long mode loads long preamble length
// - Two ramp-up symbols added to length
// - Host writes lengths only while transmit idle
// - Signal bit 4 selects filter weight set
// - Signal bit 3 selects preamble mode
// - Rate bits 1:0 select signal code
// - Host writes rate two microseconds early
// - Bits 7:5 inert, bit 2 written zero
// - Host keeps service bits zero except 7,2
// - Length high and low bytes form 16 bits
package bb_cfg_pkg;
   // ******************************************
   // Control bus register map (byte offsets)
   // ******************************************
   localparam int          ADDR_W            = 7;
   localparam int          DATA_W            = 8;
   localparam int          SAMPLE_W          = 8;
   localparam int          COUNT_W           = 9;
   localparam logic [6:0]  OFS_IDENTITY      = 7'h00;
   localparam logic [6:0]  OFS_POLARITY      = 7'h02;
   localparam logic [6:0]  OFS_SOFT_INIT     = 7'h04;
   localparam logic [6:0]  OFS_SHORT_LEN     = 7'h06;
   localparam logic [6:0]  OFS_LONG_LEN      = 7'h08;
   localparam logic [6:0]  OFS_TX_SIGNAL     = 7'h0a;
   localparam logic [6:0]  OFS_SERVICE       = 7'h0c;
   localparam logic [6:0]  OFS_LEN_HIGH      = 7'h0e;
   localparam logic [6:0]  OFS_LEN_LOW       = 7'h10;
   localparam logic [6:0]  OFS_ACQ_CONTROL   = 7'h5e;
   // ******************************************
   // Field positions
   // ******************************************
   localparam int          POL_RX_Q          = 7;
   localparam int          POL_TX_Q          = 6;
   localparam int          POL_TX_CLK        = 5;
   localparam int          POL_TX_READY      = 4;
   localparam int          POL_TX_ENABLE     = 3;
   localparam int          POL_CCA           = 2;
   localparam int          POL_RX_READY      = 1;
   localparam int          POL_RX_CLK        = 0;
   localparam int          INIT_BIT          = 0;
   localparam int          SIG_FILTER        = 4;
   localparam int          SIG_SHORT         = 3;
   localparam int          SIG_RATE_LO       = 0;
   localparam logic [7:0]  SIG_WRITE_MASK    = 8'h1b;
   localparam logic [7:0]  SERVICE_MASK      = 8'h84;
   localparam logic [7:0]  INIT_RW_MASK      = 8'hff;
   // ******************************************
   // Reset values and timing
   // ******************************************
   localparam logic [7:0]  RST_POLARITY      = 8'h00;
   localparam logic [7:0]  RST_SOFT_INIT     = 8'h00;
   localparam logic [7:0]  RST_SHORT_LEN     = 8'h38;
   localparam logic [7:0]  RST_LONG_LEN      = 8'h80;
   localparam logic [7:0]  RST_ZERO          = 8'h00;
   localparam logic [8:0]  RAMP_SYMBOLS      = 9'h002;
   // Arbitrary neutral identity codes
   localparam logic [3:0]  PART_CODE         = 4'ha;
   localparam logic [3:0]  VERSION_CODE      = 4'h5;
   // ******************************************
   // Host command and status (Wishbone word offsets)
   // ******************************************
   localparam logic [2:0]  WB_TARGET         = 3'h0;
   localparam logic [2:0]  WB_WDATA          = 3'h1;
   localparam logic [2:0]  WB_COMMAND        = 3'h2;
   localparam logic [2:0]  WB_STATUS         = 3'h3;
   localparam logic [2:0]  WB_RDATA          = 3'h4;
   localparam int          CMD_WRITE         = 0;
   localparam int          CMD_READ          = 1;
   localparam int          ST_BUSY           = 0;
   localparam int          ST_DONE           = 1;
   localparam int          ST_REFUSED        = 2;
   localparam logic [2:0]  RST_STATUS        = 3'h0;

   typedef enum logic [1:0] {
      H_IDLE  = 2'b00,
      H_ISSUE = 2'b01,
      H_WAIT  = 2'b10
   } host_state_t;
endpackage

/* File: rtl/bb_ctrl_if.sv */
// Control bus joining the host controller and the baseband register bank.
// Assumes both ends share clk_i; the bench resolves nothing, all signals are one-way.
`timescale 1ns/10ps
interface bb_ctrl_if (
   input  wire logic   clk_i
);
   logic [6:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic        reg_rvalid;
   logic        tx_enable_in;
   logic        rx_enable_in;

   modport device (
      input  reg_addr, reg_wdata, reg_wr, reg_rd, tx_enable_in, rx_enable_in,
      output reg_rdata, reg_rvalid
   );
   modport host (
      output reg_addr, reg_wdata, reg_wr, reg_rd, tx_enable_in, rx_enable_in,
      input  reg_rdata, reg_rvalid
   );
endinterface

/* File: rtl/bb_tx_config_regs.sv */
// Baseband configuration register bank with polarity steering and preamble counter.
// Assumes the host issues one-cycle strobes on the control bus on the same clock.
`timescale 1ns/10ps
module bb_tx_config_regs (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   bb_ctrl_if.device                  bus,
   input  wire logic [7:0]            rx_q_i,
   input  wire logic [7:0]            tx_q_i,
   input  wire logic                  tx_clock_i,
   input  wire logic                  rx_clock_i,
   input  wire logic                  tx_ready_i,
   input  wire logic                  cca_i,
   input  wire logic                  rx_data_ready_i,
   input  wire logic                  tx_start_i,
   input  wire logic                  symbol_tick_i,
   output logic      [7:0]            rx_q_o,
   output logic      [7:0]            tx_q_o,
   output logic                       tx_out_clock_o,
   output logic                       rx_clock_o,
   output logic                       tx_ready_o,
   output logic                       cca_o,
   output logic                       rx_data_ready_out_o,
   output logic                       tx_enable_o,
   output logic                       rx_enable_o,
   output logic                       learned_clear_o,
   output logic                       agc_reset_o,
   output logic                       filter_japan_o,
   output logic                       short_preamble_o,
   output logic      [1:0]            tx_rate_o,
   output logic      [7:0]            service_o,
   output logic      [15:0]           header_length_o,
   output logic      [8:0]            preamble_count_o,
   output logic                       preamble_active_o
);
   // ******************************************
   // State
   // ******************************************
   typedef struct packed {
      logic [7:0]  polarity;
      logic [7:0]  soft_init;
      logic [7:0]  short_len;
      logic [7:0]  long_len;
      logic [7:0]  tx_signal;
      logic [7:0]  service;
      logic [7:0]  len_high;
      logic [7:0]  len_low;
      logic [7:0]  rdata;
      logic        rvalid;
      logic [2:0]  tx_sync;
      logic [2:0]  rx_sync;
      logic        tx_pin;
      logic        rx_pin;
      logic [7:0]  rx_q;
      logic [7:0]  tx_q;
      logic [5:0]  lines;
      logic [8:0]  pre_count;
      logic        pre_active;
   } dev_state_t;

   dev_state_t  st;
   dev_state_t  next_st;

   // Accept a pin change only once the last two stages agree
   function automatic logic settle(input logic [2:0] s, input logic old);
      settle = (s[1] == s[2]) ? s[2] : old;
   endfunction

   function automatic logic [7:0] read_mux(input dev_state_t s, input logic [6:0] a);
      unique case (a)
         bb_cfg_pkg::OFS_IDENTITY:  read_mux = {bb_cfg_pkg::PART_CODE,
                                               bb_cfg_pkg::VERSION_CODE};
         bb_cfg_pkg::OFS_POLARITY:  read_mux = s.polarity;
         bb_cfg_pkg::OFS_SOFT_INIT: read_mux = s.soft_init;
         bb_cfg_pkg::OFS_SHORT_LEN: read_mux = s.short_len;
         bb_cfg_pkg::OFS_LONG_LEN:  read_mux = s.long_len;
         bb_cfg_pkg::OFS_TX_SIGNAL: read_mux = s.tx_signal;
         bb_cfg_pkg::OFS_SERVICE:   read_mux = s.service;
         bb_cfg_pkg::OFS_LEN_HIGH:  read_mux = s.len_high;
         bb_cfg_pkg::OFS_LEN_LOW:   read_mux = s.len_low;
         default:                   read_mux = bb_cfg_pkg::RST_ZERO;
      endcase
   endfunction

   // ******************************************
   // Next state
   // ******************************************
   always_comb begin
      logic [7:0]  sel_len;
      logic [7:0]  pol;
      sel_len = 8'h00;
      pol     = st.polarity;
      next_st = st;
      next_st.rvalid = bus.reg_rd;
      if (bus.reg_rd) begin
         next_st.rdata = read_mux(st, bus.reg_addr);
      end
      // Identity has no write path, so stray writes there fall away
      if (bus.reg_wr) begin
         unique case (bus.reg_addr)
            bb_cfg_pkg::OFS_POLARITY:  next_st.polarity  = bus.reg_wdata;
            bb_cfg_pkg::OFS_SOFT_INIT: next_st.soft_init = bus.reg_wdata;
            bb_cfg_pkg::OFS_SHORT_LEN: next_st.short_len = bus.reg_wdata;
            bb_cfg_pkg::OFS_LONG_LEN:  next_st.long_len  = bus.reg_wdata;
            bb_cfg_pkg::OFS_TX_SIGNAL: next_st.tx_signal = bus.reg_wdata;
            bb_cfg_pkg::OFS_SERVICE:   next_st.service   = bus.reg_wdata;
            bb_cfg_pkg::OFS_LEN_HIGH:  next_st.len_high  = bus.reg_wdata;
            bb_cfg_pkg::OFS_LEN_LOW:   next_st.len_low   = bus.reg_wdata;
            default:                   next_st.rvalid    = bus.reg_rd;
         endcase
      end
      next_st.tx_sync = {st.tx_sync[1:0], bus.tx_enable_in};
      next_st.rx_sync = {st.rx_sync[1:0], bus.rx_enable_in};
      next_st.tx_pin  = settle(st.tx_sync, st.tx_pin);
      next_st.rx_pin  = settle(st.rx_sync, st.rx_pin);
      // Ones' complement keeps full-scale samples from overflowing
      next_st.rx_q = pol[bb_cfg_pkg::POL_RX_Q] ? ~rx_q_i : rx_q_i;
      next_st.tx_q = pol[bb_cfg_pkg::POL_TX_Q] ? ~tx_q_i : tx_q_i;
      next_st.lines[5] = tx_clock_i ^ pol[bb_cfg_pkg::POL_TX_CLK];
      next_st.lines[4] = tx_ready_i ^ pol[bb_cfg_pkg::POL_TX_READY];
      next_st.lines[3] = st.tx_pin ^ pol[bb_cfg_pkg::POL_TX_ENABLE];
      next_st.lines[2] = ~(cca_i ^ pol[bb_cfg_pkg::POL_CCA]);
      next_st.lines[1] = rx_data_ready_i ^ pol[bb_cfg_pkg::POL_RX_READY];
      next_st.lines[0] = rx_clock_i ^ pol[bb_cfg_pkg::POL_RX_CLK];
      // ******************************************
      // Preamble length counter
      // ******************************************
      if (st.tx_signal[bb_cfg_pkg::SIG_SHORT]) begin
         sel_len = st.short_len;
      end else begin
         sel_len = st.long_len;
      end
      if (tx_start_i) begin
         next_st.pre_count = {1'b0, sel_len} + bb_cfg_pkg::RAMP_SYMBOLS;
      end else if (symbol_tick_i && (st.pre_count != 9'h000)) begin
         next_st.pre_count = st.pre_count - 9'h001;
      end
      next_st.pre_active = (next_st.pre_count != 9'h000);
      if (rst_i) begin
         next_st           = '0;
         next_st.polarity  = bb_cfg_pkg::RST_POLARITY;
         next_st.soft_init = bb_cfg_pkg::RST_SOFT_INIT;
         next_st.short_len = bb_cfg_pkg::RST_SHORT_LEN;
         next_st.long_len  = bb_cfg_pkg::RST_LONG_LEN;
      end
   end

   always_ff @(posedge clk_i) begin
      st <= next_st;
   end

   // ******************************************
   // Outputs
   // ******************************************
   assign bus.reg_rdata         = st.rdata;
   assign bus.reg_rvalid        = st.rvalid;
   assign rx_q_o                = st.rx_q;
   assign tx_q_o                = st.tx_q;
   assign tx_out_clock_o        = st.lines[5];
   assign tx_ready_o            = st.lines[4];
   assign tx_enable_o           = st.lines[3];
   assign cca_o                 = st.lines[2];
   assign rx_data_ready_out_o   = st.lines[1];
   assign rx_clock_o            = st.lines[0];
   assign rx_enable_o           = st.rx_pin;
   assign learned_clear_o       = st.soft_init[bb_cfg_pkg::INIT_BIT];
   assign agc_reset_o           = st.soft_init[bb_cfg_pkg::INIT_BIT];
   assign filter_japan_o        = st.tx_signal[bb_cfg_pkg::SIG_FILTER];
   assign short_preamble_o      = st.tx_signal[bb_cfg_pkg::SIG_SHORT];
   assign tx_rate_o             = st.tx_signal[1:0];
   assign service_o             = st.service;
   assign header_length_o       = {st.len_high, st.len_low};
   assign preamble_count_o      = st.pre_count;
   assign preamble_active_o     = st.pre_active;
endmodule

/* File: rtl/bb_host_ctrl.sv */
// Host controller: a Wishbone slave that turns software orders into control-bus cycles.
// Assumes the register bank answers a read one cycle after the read strobe.
`timescale 1ns/10ps
module bb_host_ctrl (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   bb_ctrl_if.host           bus,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [7:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   input  wire logic         tx_active_i,
   input  wire logic         rx_active_i
);
   typedef struct packed {
      bb_cfg_pkg::host_state_t  fsm;
      logic [6:0]               target;
      logic [7:0]               wdata;
      logic [7:0]               rdata;
      logic [2:0]               status;
      logic                     pol_tx_enable;
      logic                     op_read;
      logic                     wr;
      logic                     rd;
      logic                     tx_pin;
      logic                     rx_pin;
      logic                     ack;
      logic [31:0]              dat;
   } host_st_t;

   host_st_t  st;
   host_st_t  next_st;

   // Configuration that must not move while a frame may run
   function automatic logic guarded(input logic [6:0] a);
      guarded = (a == bb_cfg_pkg::OFS_SOFT_INIT) || (a == bb_cfg_pkg::OFS_SHORT_LEN)
             || (a == bb_cfg_pkg::OFS_LONG_LEN);
   endfunction

   function automatic logic [7:0] clean(input logic [6:0] a, input logic [7:0] d);
      if (a == bb_cfg_pkg::OFS_TX_SIGNAL) begin
         clean = d & bb_cfg_pkg::SIG_WRITE_MASK;
      end else if (a == bb_cfg_pkg::OFS_SERVICE) begin
         clean = d & bb_cfg_pkg::SERVICE_MASK;
      end else begin
         clean = d & bb_cfg_pkg::INIT_RW_MASK;
      end
   endfunction

   always_comb begin
      logic        req;
      logic        go_wr;
      logic        go_rd;
      logic [2:0]  done_set;
      req      = wb_cyc_i && wb_stb_i && !st.ack;
      go_wr    = req && wb_we_i && wb_sel_i[0] && (wb_adr_i[4:2] == bb_cfg_pkg::WB_COMMAND)
              && wb_dat_i[bb_cfg_pkg::CMD_WRITE];
      go_rd    = req && wb_we_i && wb_sel_i[0] && (wb_adr_i[4:2] == bb_cfg_pkg::WB_COMMAND)
              && wb_dat_i[bb_cfg_pkg::CMD_READ] && !wb_dat_i[bb_cfg_pkg::CMD_WRITE];
      done_set = 3'h0;
      next_st  = st;
      next_st.ack = req;
      next_st.wr  = 1'b0;
      next_st.rd  = 1'b0;
      // The transmit enable pin follows the polarity the bank was last told; receive enable passes straight
      next_st.tx_pin = tx_active_i ^ st.pol_tx_enable;
      next_st.rx_pin = rx_active_i;
      if (req && !wb_we_i) begin
         unique case (wb_adr_i[4:2])
            bb_cfg_pkg::WB_TARGET: next_st.dat = {25'h0, st.target};
            bb_cfg_pkg::WB_WDATA:  next_st.dat = {24'h0, st.wdata};
            bb_cfg_pkg::WB_STATUS: next_st.dat = {29'h0, st.status};
            bb_cfg_pkg::WB_RDATA:  next_st.dat = {24'h0, st.rdata};
            default:               next_st.dat = 32'h0;
         endcase
      end
      unique case (st.fsm)
         bb_cfg_pkg::H_IDLE: begin
            if (go_wr && guarded(st.target) && (tx_active_i || rx_active_i)) begin
               done_set[bb_cfg_pkg::ST_REFUSED] = 1'b1;
            end else if (go_wr || go_rd) begin
               next_st.fsm     = bb_cfg_pkg::H_ISSUE;
               next_st.op_read = go_rd;
               next_st.wr      = go_wr;
               next_st.rd      = go_rd;
               if (go_wr && (st.target == bb_cfg_pkg::OFS_POLARITY)) begin
                  next_st.pol_tx_enable = st.wdata[bb_cfg_pkg::POL_TX_ENABLE];
               end
            end
         end
         bb_cfg_pkg::H_ISSUE: begin
            if (st.op_read) begin
               next_st.fsm = bb_cfg_pkg::H_WAIT;
            end else begin
               next_st.fsm = bb_cfg_pkg::H_IDLE;
               done_set[bb_cfg_pkg::ST_DONE] = 1'b1;
            end
         end
         bb_cfg_pkg::H_WAIT: begin
            if (bus.reg_rvalid) begin
               next_st.rdata = bus.reg_rdata;
               next_st.fsm   = bb_cfg_pkg::H_IDLE;
               done_set[bb_cfg_pkg::ST_DONE] = 1'b1;
            end
         end
         default: next_st.fsm = bb_cfg_pkg::H_IDLE;
      endcase
      if (req && wb_we_i && wb_sel_i[0]) begin
         unique case (wb_adr_i[4:2])
            bb_cfg_pkg::WB_TARGET: if (st.fsm == bb_cfg_pkg::H_IDLE) begin
               next_st.target = wb_dat_i[6:0];
            end
            bb_cfg_pkg::WB_WDATA:  if (st.fsm == bb_cfg_pkg::H_IDLE) begin
               next_st.wdata = clean(st.target, wb_dat_i[7:0]);
            end
            bb_cfg_pkg::WB_STATUS: begin
               next_st.status[2:1] = st.status[2:1] & ~wb_dat_i[2:1];
            end
            default: next_st.dat = st.dat;
         endcase
      end
      // A completion in the clearing cycle still sets its flag
      next_st.status[2:1] = next_st.status[2:1] | done_set[2:1];
      next_st.status[bb_cfg_pkg::ST_BUSY] = (next_st.fsm != bb_cfg_pkg::H_IDLE);
      if (rst_i) begin
         next_st        = '0;
         next_st.fsm    = bb_cfg_pkg::H_IDLE;
         next_st.status = bb_cfg_pkg::RST_STATUS;
      end
   end

   always_ff @(posedge clk_i) begin
      st <= next_st;
   end

   // Writes to the acquisition register are ordinary cycles; ordering is software's
   assign bus.reg_addr     = st.target;
   assign bus.reg_wdata    = st.wdata;
   assign bus.reg_wr       = st.wr;
   assign bus.reg_rd       = st.rd;
   assign bus.tx_enable_in = st.tx_pin;
   assign bus.rx_enable_in = st.rx_pin;
   assign wb_dat_o         = st.dat;
   assign wb_ack_o         = st.ack;
endmodule

/* File: verif/bb_cfg_checker.sv */
// Checker on the control bus between host controller and register bank.
// Assumes one clock domain; the bench instantiates it beside the interface.
`timescale 1ns/10ps
module bb_cfg_checker (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [6:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid,
   input  wire logic       tx_enable_in,
   input  wire logic       rx_enable_in
);
   // **********
   // Shadow of what the host wrote
   // **********
   logic [7:0] sh [16];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sh <= '{3: 8'h38, 4: 8'h80, default: 8'h00};
      end else if (reg_wr && reg_addr[6:5] == 2'b00 && !reg_addr[0] && reg_addr != 7'h00) begin
         sh[reg_addr[4:1]] <= reg_wdata;
      end
   end
   // **********
   // Properties
   // **********
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_rd(logic [6:0] a); reg_rd && reg_addr == a; endsequence
   sequence s_ans(logic [7:0] v); reg_rvalid && reg_rdata == v ##1 !reg_rvalid; endsequence
   property p_ident;
      s_rd(7'h00) |=> s_ans({bb_cfg_pkg::PART_CODE, bb_cfg_pkg::VERSION_CODE}); endproperty
   a_ident: assert property (p_ident) else $error("identity read wrong");
   property p_pol; s_rd(7'h02) |=> s_ans(sh[1]); endproperty
   a_pol: assert property (p_pol) else $error("polarity read wrong");
   property p_init; s_rd(7'h04) |=> s_ans(sh[2]); endproperty
   a_init: assert property (p_init) else $error("init read wrong");
   property p_short; s_rd(7'h06) |=> s_ans(sh[3]); endproperty
   a_short: assert property (p_short) else $error("short length read wrong");
   property p_long; s_rd(7'h08) |=> s_ans(sh[4]); endproperty
   a_long: assert property (p_long) else $error("long length read wrong");
   property p_sig; s_rd(7'h0a) |=> s_ans(sh[5]); endproperty
   a_sig: assert property (p_sig) else $error("signal read wrong");
   property p_len; s_rd(7'h10) |=> s_ans(sh[8]); endproperty
   a_len: assert property (p_len) else $error("length low read wrong");
   property p_svc; reg_wr && reg_addr == 7'h0c |-> (reg_wdata & 8'h7b) == 8'h00; endproperty
   a_svc: assert property (p_svc) else $error("service bits not zero");
   property p_len_idle;
      reg_wr && reg_addr inside {7'h06, 7'h08} |-> tx_enable_in == sh[1][3]; endproperty
   a_len_idle: assert property (p_len_idle) else $error("length written in transmit");
   property p_init_idle;
      reg_wr && reg_addr == 7'h04 |-> !rx_enable_in && tx_enable_in == sh[1][3]; endproperty
   a_init_idle: assert property (p_init_idle) else $error("init written while enabled");
endmodule

/* File: verif/baseband_tx_config_registers_bench.sv */
// Bench: host controller and register bank joined by the control bus.
// Assumes package, interface, both design modules and the checker compile first.
`timescale 1ns/10ps
module baseband_tx_config_registers_bench;
   // **********
   // Signals
   // **********
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic        start = 1'b0, tick = 1'b0, txa = 1'b0, rxa = 1'b0;
   logic [7:0]  adr = 8'h00, rxq = 8'h00, txq = 8'h00;
   logic [4:0]  lv = 5'h00;
   logic [31:0] wdat = 32'h0, rdat;
   wire  [4:0]  lv_o;
   logic [7:0]  rxq_o, txq_o, svc_o, exp_q [$];
   logic        txen, rxen, lclr, agcr, jap, shp, pact;
   logic [1:0]  rate;
   logic [15:0] hlen;
   logic [8:0]  pcnt;
   int          n_mismatch = 0, total_checks = 0, cycles = 0;
   always #2.5 clk_i = ~clk_i;
   bb_ctrl_if bb_ctrl_if_i (.clk_i(clk_i));
   bb_host_ctrl bb_host_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .bus(bb_ctrl_if_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .tx_active_i(txa), .rx_active_i(rxa));
   bb_tx_config_regs bb_tx_config_regs_i (.clk_i(clk_i), .rst_i(rst_i), .bus(bb_ctrl_if_i),
      .rx_q_i(rxq), .tx_q_i(txq), .tx_clock_i(lv[4]), .rx_clock_i(lv[3]), .tx_ready_i(lv[2]),
      .cca_i(lv[1]), .rx_data_ready_i(lv[0]), .tx_start_i(start), .symbol_tick_i(tick),
      .rx_q_o(rxq_o), .tx_q_o(txq_o), .tx_out_clock_o(lv_o[4]), .rx_clock_o(lv_o[3]),
      .tx_ready_o(lv_o[2]), .cca_o(lv_o[1]), .rx_data_ready_out_o(lv_o[0]), .tx_enable_o(txen),
      .rx_enable_o(rxen), .learned_clear_o(lclr), .agc_reset_o(agcr), .filter_japan_o(jap),
      .short_preamble_o(shp), .tx_rate_o(rate), .service_o(svc_o), .header_length_o(hlen),
      .preamble_count_o(pcnt), .preamble_active_o(pact));
   bb_cfg_checker bb_cfg_checker_i (.clk_i(clk_i), .rst_i(rst_i),
      .reg_addr(bb_ctrl_if_i.reg_addr), .reg_wdata(bb_ctrl_if_i.reg_wdata),
      .reg_wr(bb_ctrl_if_i.reg_wr), .reg_rd(bb_ctrl_if_i.reg_rd),
      .reg_rdata(bb_ctrl_if_i.reg_rdata), .reg_rvalid(bb_ctrl_if_i.reg_rvalid),
      .tx_enable_in(bb_ctrl_if_i.tx_enable_in), .rx_enable_in(bb_ctrl_if_i.rx_enable_in));
   // **********
   // Tasks
   // **********
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Holds the request until ack is sampled, then idles one cycle
   task automatic wb(input logic w, input logic [2:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {3'h0, idx, 2'h0};
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   // Target first: the host masks write data by the target it holds
   task automatic cmd(input logic [6:0] ofs, input logic [7:0] d, input logic [1:0] go,
                      output logic [31:0] q);
      logic [31:0] s;
      wb(1'b1, 3'h0, 32'(ofs), q);
      wb(1'b1, 3'h1, 32'(d), q);
      wb(1'b1, 3'h2, 32'(go), q);
      do wb(1'b0, 3'h3, 32'h0, q); while (q[2:1] == 2'b00);
      wb(1'b1, 3'h3, 32'h6, s);
   endtask
   task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
      logic [31:0] q;
      cmd(ofs, d, 2'b01, q);
   endtask
   task automatic rd(input logic [6:0] ofs, input logic [7:0] e);
      logic [31:0] q;
      exp_q.push_back(e);
      cmd(ofs, 8'h00, 2'b10, q);
      wb(1'b0, 3'h4, 32'h0, q);
      check("rdata", 16'(q[7:0]), 16'(e));
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (bb_ctrl_if_i.reg_rvalid === 1'b1 && exp_q.size() > 0)
         check("reg_rdata", 16'(bb_ctrl_if_i.reg_rdata), 16'(exp_q.pop_front()));
      if (cycles == 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   // **********
   // Tests
   // **********
   initial begin
      logic [7:0]  v, e, sl, rtab [9];
      logic [31:0] q;
      rtab = '{{bb_cfg_pkg::PART_CODE, bb_cfg_pkg::VERSION_CODE}, 8'h00, 8'h00, 8'h38, 8'h80,
               8'h00, 8'h00, 8'h00, 8'h00};
      void'($urandom(83));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (rtab[i]) rd(7'(2 * i), rtab[i]);
      wr(7'h00, 8'h3c);
      rd(7'h00, rtab[0]);
      rd(7'h12, 8'h00);
      wb(1'b0, 3'h7, 32'h0, q);
      check("wb_unmapped", q[15:0], 16'h0000);
      $display("test reset_map finished");
      for (int i = 0; i < 10; i++) begin
         v = (i < 8) ? 8'(1 << i) : 8'($urandom);
         wr(7'h02, v);
         {rxq, txq} <= 16'($urandom);
         lv  <= 5'($urandom);
         {txa, rxa} <= 2'($urandom);
         repeat (8) @(posedge clk_i);
         #1;
         check("q_samples", {rxq_o, txq_o}, {rxq ^ {8{v[7]}}, txq ^ {8{v[6]}}});
         check("levels", 16'(lv_o), 16'(lv ^ {v[5], v[0], v[4], ~v[2], v[1]}));
         check("enables", 16'({txen, rxen}), 16'({txa, rxa}));
         check("tx_pin", 16'(bb_ctrl_if_i.tx_enable_in), 16'(txa ^ v[3]));
         @(posedge clk_i);
      end
      txa <= 1'b0;
      rxa <= 1'b1;
      repeat (8) @(posedge clk_i);
      cmd(7'h04, 8'h01, 2'b01, q);
      check("init_refused", 16'({q[2], lclr}), 16'h0002);
      rxa <= 1'b0;
      repeat (8) @(posedge clk_i);
      wr(7'h04, 8'h01);
      check("learned_clear", 16'({lclr, agcr}), 16'h0003);
      rd(7'h04, 8'h01);
      wr(bb_cfg_pkg::OFS_ACQ_CONTROL, 8'($urandom));
      wr(7'h04, 8'h00);
      check("learned_clear", 16'({lclr, agcr}), 16'h0000);
      $display("test polarity_init finished");
      for (int r = 0; r < 4; r++) begin
         v = (8'($urandom) & 8'hfc) | 8'(r);
         wr(7'h0a, v);
         check("signal", 16'({jap, shp, rate}), 16'({v[4:3], v[1:0]}));
         rd(7'h0a, v & 8'h1b);
      end
      v = 8'($urandom);
      e = 8'($urandom);
      wr(7'h0c, v);
      check("service", 16'(svc_o), 16'(v & 8'h84));
      wr(7'h0e, v);
      wr(7'h10, e);
      check("length", hlen, {v, e});
      rd(7'h10, e);
      sl = 8'h38 + 8'($urandom % 64);
      wr(7'h06, sl);
      wr(7'h08, 8'h80);
      for (int m = 0; m < 2; m++) begin
         wr(7'h0a, 8'(m << 3));
         repeat (400) @(posedge clk_i);
         e = (m == 1) ? sl : 8'h80;
         start <= 1'b1;
         @(posedge clk_i);
         start <= 1'b0;
         #1;
         check("preamble", 16'({pact, pcnt}), 16'({1'b1, 9'(e) + 9'h002}));
         @(posedge clk_i);
         tick <= 1'b1;
         @(posedge clk_i);
         tick <= 1'b0;
         #1;
         check("preamble_tick", 16'(pcnt), 16'(9'(e) + 9'h001));
         @(posedge clk_i);
      end
      txa <= 1'b1;
      repeat (8) @(posedge clk_i);
      cmd(7'h06, 8'h55, 2'b01, q);
      check("len_refused", 16'(q[2]), 16'h0001);
      txa <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd(7'h06, sl);
      $display("test tx_header finished");
      final_report();
   end
endmodule
